// ### dll_ctrl_defines.vh
/*
  register indices, field positions, reset values and timing counts
  for the memory clock delay-locked loop control block.
  assumes it is included by bare name from the tracker and control design files.
*/
`ifndef DLL_CTRL_DEFINES_VH
`define DLL_CTRL_DEFINES_VH

// ----------------------------------------------------------------
// register indices (word address on the bus, byte address = 4x)
// ----------------------------------------------------------------
`define IDX_PWR_CFG2        8'h72
`define IDX_DRIVE_STRENGTH  8'h73
`define IDX_MISC_IO_CTRL1   8'h76
`define IDX_INPUT_TIMING    8'h77
`define IDX_ADDR_MAP_B_OPT  8'he0
`define IDX_TAP_COUNT       8'he3
`define IDX_DLL_STATUS      8'he4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_DLL_EXTEND      7
`define BIT_DLL_MAX_DELAY   2
`define BIT_DLL_TAP_REINIT  5
`define BIT_SAMPLE_HI       5
`define BIT_SAMPLE_LO       4
`define BIT_STAT_LOCKED     0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PWR_CFG2        8'h00
`define RST_DRIVE_STRENGTH  8'h00
`define RST_MISC_IO_CTRL1   8'h00
`define RST_INPUT_TIMING    8'h00
`define RST_ADDR_MAP_B_OPT  8'h00

// ----------------------------------------------------------------
// delay line and timing
// ----------------------------------------------------------------
`define TAP_LAST_MAX        7'h7f
`define TAP_LAST_NORMAL     7'h3f
`define TAP_INIT            7'h08
`define TAP_OFFSET          7'h02
`define UPDATE_NS           64
`define CLK_PERIOD_NS       8
`define UPDATE_CYCLES       (`UPDATE_NS / `CLK_PERIOD_NS)
`define LOCK_REVERSALS      4
`define LOCK_REVERSALS_EXT  8

`endif

// ### strap_sampler.v
/*
  captures the five system pll ratio straps once after reset release.
  assumes the strap pins are static around reset and asynchronous to
  ref_clk, so they pass two flip-flops before being caught.
*/
`timescale 1ns/1ps
module strap_sampler
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire [4:0] strap_pins,
  output reg  [4:0] ratio_r,
  output reg        valid_r
);

  reg [4:0] meta_r;
  reg [4:0] sync_r;
  reg [1:0] settle_r;

  // ----------------------------------------------------------------
  // synchroniser and one-shot capture
  // ----------------------------------------------------------------
  // capture waits three edges so the synchroniser holds real pin data
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r   <= 5'h00;
      sync_r   <= 5'h00;
      settle_r <= 2'h0;
      ratio_r  <= 5'h00;
      valid_r  <= 1'b0;
    end
    else
    begin
      meta_r <= strap_pins;
      sync_r <= meta_r;
      if (settle_r != 2'h3)
        settle_r <= settle_r + 2'h1;
      else if (!valid_r)
      begin
        ratio_r <= sync_r;
        valid_r <= 1'b1;
      end
    end
  end

endmodule

// ### dll_tap_tracker.v
/*
  digital tap controller of the memory clock delay line.
  assumes an analog phase detector on the pin phase_late, high when the
  fed-back memory clock arrives after the system logic clock.
*/
`timescale 1ns/1ps
`include "dll_ctrl_defines.vh"
module dll_tap_tracker
#(
  parameter [6:0] TAP_INIT    = `TAP_INIT,
  parameter [6:0] TAP_OFFSET  = `TAP_OFFSET,
  parameter       UPDATE_CYC  = `UPDATE_CYCLES
)
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       phase_late,
  input  wire       max_delay,
  input  wire       extend,
  input  wire       reinit,
  output reg  [6:0] tap_r,
  output reg  [6:0] line_sel_r,
  output reg        locked_r
);

  reg  [1:0]  ph_sync_r;
  reg  [15:0] div_r;
  reg         tick_r;
  reg         last_dir_r;
  reg  [3:0]  rev_r;
  wire [6:0]  last_tap;
  wire [3:0]  need_rev;

  localparam [3:0] REV_NORMAL = `LOCK_REVERSALS;
  localparam [3:0] REV_EXT    = `LOCK_REVERSALS_EXT;

  assign last_tap = max_delay ? `TAP_LAST_MAX : `TAP_LAST_NORMAL;
  assign need_rev = extend ? REV_EXT : REV_NORMAL;

  // ----------------------------------------------------------------
  // update rate divider
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (div_r == UPDATE_CYC[15:0] - 16'h0001)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // tap tracking toward the system logic clock
  // ----------------------------------------------------------------
  // extended locking lets the search wrap at the ends of the line,
  // trading a longer lock time for a wider capture range
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_sync_r  <= 2'h0;
      tap_r      <= 7'h00;
      line_sel_r <= 7'h00;
      last_dir_r <= 1'b0;
      rev_r      <= 4'h0;
      locked_r   <= 1'b0;
    end
    else
    begin
      ph_sync_r  <= {ph_sync_r[0], phase_late};
      line_sel_r <= (tap_r > TAP_OFFSET) ? tap_r - TAP_OFFSET
                                         : 7'h00;
      if (reinit)
      begin
        tap_r    <= TAP_INIT;
        rev_r    <= 4'h0;
        locked_r <= 1'b0;
      end
      else if (tick_r)
      begin
        if (ph_sync_r[1])
        begin
          if (tap_r != 7'h00)
            tap_r <= tap_r - 7'h01;
          else if (extend)
            tap_r <= last_tap;
        end
        else
        begin
          if (tap_r < last_tap)
            tap_r <= tap_r + 7'h01;
          else if (extend)
            tap_r <= 7'h00;
          else
            tap_r <= last_tap;
        end
        last_dir_r <= ph_sync_r[1];
        if (ph_sync_r[1] != last_dir_r && rev_r != need_rev)
          rev_r <= rev_r + 4'h1;
        if (rev_r == need_rev)
          locked_r <= 1'b1;
      end
    end
  end

endmodule

// ### dll_ctrl.v
/*
  memory clock delay-locked loop control: register file on an
  avalon-mm slave with waitrequest, lock mode selection, tap reinit,
  tap readback, drive strength and input timing configuration, and
  pll ratio strap capture.
  assumes ref_clk is the system logic clock, and that the analog delay
  line, both plls and the pad drivers sit outside this block.
  the lock mode bits act on the tracker at once; a change after init
  is not guarded here.

  // Contract
  // - four lock modes from two select bits
  // - max-delay bit picks tap range; extend independent
  // - reinit bit sets delay line initial tap
  // - locked tap readable in bits 6-0
  // - loop aligns memory clock to system clock
  // - pll ratio straps sampled at reset
  // - system pll follows pci clock; separate core pll
  // - drive strength byte held for pads
  // - memory clock is multiple of pci clock
  // - feedback internal offset compensated by loop
  // - two bits select input setup/hold trade
*/
`timescale 1ns/1ps
`include "dll_ctrl_defines.vh"
module dll_ctrl
#(
  parameter [6:0] TAP_INIT   = `TAP_INIT,
  parameter [6:0] TAP_OFFSET = `TAP_OFFSET,
  parameter       UPDATE_CYC = `UPDATE_CYCLES
)
(
  input  wire       ref_clk,
  input  wire       arst_n,
  input  wire [7:0] address,
  input  wire       read,
  input  wire       write,
  input  wire [7:0] writedata,
  output reg  [7:0] readdata,
  output reg        waitrequest,
  input  wire       phase_late,
  input  wire [4:0] pll_ratio_pins,
  output reg  [4:0] sys_pll_ratio_r,
  output reg        sys_pll_cfg_valid_r,
  output reg  [6:0] delay_line_sel_r,
  output reg        dll_locked_r,
  output reg  [7:0] drive_strength_r,
  output reg  [1:0] input_timing_sel_r
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_r;
  reg rst_n_r;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [7:0] pwr_cfg2_r;
  reg  [7:0] drive_cfg_r;
  reg  [7:0] misc_io_ctrl1_r;
  reg  [7:0] input_timing_r;
  reg  [7:0] addr_map_b_opt_r;
  reg  [7:0] rd_nxt;
  reg        rd_hit;

  wire [6:0] tap_count;
  wire [6:0] line_sel;
  wire       locked;
  wire [4:0] ratio;
  wire       ratio_valid;
  wire       wr_commit;

  // a write lands only at the edge where the master sees waitrequest
  // low, so a held request is never applied twice
  assign wr_commit = write && !waitrequest;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function [7:0] read_mux;
    input [7:0] idx;
    input [7:0] r72;
    input [7:0] r73;
    input [7:0] r76;
    input [7:0] r77;
    input [7:0] re0;
    input [6:0] tap;
    input [7:0] stat;
    begin
      if (idx == `IDX_PWR_CFG2)
        read_mux = r72;
      else if (idx == `IDX_DRIVE_STRENGTH)
        read_mux = r73;
      else if (idx == `IDX_MISC_IO_CTRL1)
        read_mux = r76;
      else if (idx == `IDX_INPUT_TIMING)
        read_mux = r77;
      else if (idx == `IDX_ADDR_MAP_B_OPT)
        read_mux = re0;
      else if (idx == `IDX_TAP_COUNT)
        read_mux = {1'b0, tap};
      else if (idx == `IDX_DLL_STATUS)
        read_mux = stat;
      else
        read_mux = 8'h00;
    end
  endfunction

  always @*
  begin
    rd_hit = 1'b1;
    rd_nxt = read_mux(address, pwr_cfg2_r, drive_cfg_r,
                      misc_io_ctrl1_r, input_timing_r,
                      addr_map_b_opt_r, tap_count,
                      {2'h0, ratio, locked});
    if (!read)
      rd_hit = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait cycle per access: readdata is loaded while waitrequest
  // falls and stands at the edge the master samples it
  always @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      waitrequest <= 1'b1;
      readdata    <= 8'h00;
    end
    else if ((read || write) && waitrequest)
    begin
      waitrequest <= 1'b0;
      if (rd_hit)
        readdata <= rd_nxt;
    end
    else
    begin
      waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // lock mode bits take effect at once and no new search is started,
  // so software sets them only at init
  always @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pwr_cfg2_r       <= `RST_PWR_CFG2;
      drive_cfg_r      <= `RST_DRIVE_STRENGTH;
      misc_io_ctrl1_r  <= `RST_MISC_IO_CTRL1;
      input_timing_r   <= `RST_INPUT_TIMING;
      addr_map_b_opt_r <= `RST_ADDR_MAP_B_OPT;
    end
    else if (wr_commit)
    begin
      if (address == `IDX_PWR_CFG2)
        pwr_cfg2_r <= writedata;
      else if (address == `IDX_DRIVE_STRENGTH)
        drive_cfg_r <= writedata;
      else if (address == `IDX_MISC_IO_CTRL1)
        misc_io_ctrl1_r <= writedata;
      else if (address == `IDX_INPUT_TIMING)
        input_timing_r <= writedata;
      else if (address == `IDX_ADDR_MAP_B_OPT)
        addr_map_b_opt_r <= writedata;
    end
    // the tap count and status indices accept no writes
  end

  // ----------------------------------------------------------------
  // lock mode decode
  // ----------------------------------------------------------------
  localparam [1:0] MODE_NORM     = 2'b00;
  localparam [1:0] MODE_NORM_EXT = 2'b01;
  localparam [1:0] MODE_MAX      = 2'b10;
  localparam [1:0] MODE_MAX_EXT  = 2'b11;

  wire [1:0] lock_mode;
  reg        mode_max_delay;
  reg        mode_extend;

  // the two select bits sit in different registers; joining them
  // here keeps all four modes in one decode
  assign lock_mode = {misc_io_ctrl1_r[`BIT_DLL_MAX_DELAY],
                      pwr_cfg2_r[`BIT_DLL_EXTEND]};

  // decoded without a register so the tracker sees a new mode on the
  // edge after the write, like the other configuration bits
  always @*
  begin
    mode_max_delay = 1'b0;
    mode_extend    = 1'b0;
    case (lock_mode)
      MODE_NORM:
      begin
        mode_max_delay = 1'b0;
        mode_extend    = 1'b0;
      end
      MODE_NORM_EXT:
      begin
        mode_max_delay = 1'b0;
        mode_extend    = 1'b1;
      end
      MODE_MAX:
      begin
        mode_max_delay = 1'b1;
        mode_extend    = 1'b0;
      end
      MODE_MAX_EXT:
      begin
        mode_max_delay = 1'b1;
        mode_extend    = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // delay line control
  // ----------------------------------------------------------------
  dll_tap_tracker
  #(
    .TAP_INIT   (TAP_INIT),
    .TAP_OFFSET (TAP_OFFSET),
    .UPDATE_CYC (UPDATE_CYC)
  )
  u_tracker
  (
    .clk        (ref_clk),
    .rst_n      (rst_n_r),
    .phase_late (phase_late),
    .max_delay  (mode_max_delay),
    .extend     (mode_extend),
    .reinit     (addr_map_b_opt_r[`BIT_DLL_TAP_REINIT]),
    .tap_r      (tap_count),
    .line_sel_r (line_sel),
    .locked_r   (locked)
  );

  // ----------------------------------------------------------------
  // pll ratio straps
  // ----------------------------------------------------------------
  // the ratio sets system and memory clocks as a multiple of the pci
  // clock; the core pll has its own straps and is not driven here
  strap_sampler u_straps
  (
    .clk        (ref_clk),
    .rst_n      (rst_n_r),
    .strap_pins (pll_ratio_pins),
    .ratio_r    (ratio),
    .valid_r    (ratio_valid)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sys_pll_ratio_r     <= 5'h00;
      sys_pll_cfg_valid_r <= 1'b0;
      delay_line_sel_r    <= 7'h00;
      dll_locked_r        <= 1'b0;
      drive_strength_r    <= `RST_DRIVE_STRENGTH;
      input_timing_sel_r  <= 2'h0;
    end
    else
    begin
      sys_pll_ratio_r     <= ratio;
      sys_pll_cfg_valid_r <= ratio_valid;
      delay_line_sel_r    <= line_sel;
      dll_locked_r        <= locked;
      drive_strength_r    <= drive_cfg_r;
      input_timing_sel_r  <= {input_timing_r[`BIT_SAMPLE_HI],
                              input_timing_r[`BIT_SAMPLE_LO]};
    end
  end

endmodule

// ### dll_ctrl_chk.sv
/*
  port checker for dll_ctrl: bus handshake, read refusals, field
  outputs, strap capture and tap reinit.
  assumes it is bound into dll_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module dll_ctrl_chk
#(
  parameter [6:0] TAP_INIT   = 7'h08,
  parameter [6:0] TAP_OFFSET = 7'h02,
  parameter       UPDATE_CYC = 8
)
(
  input logic       ref_clk,
  input logic       arst_n,
  input logic [7:0] address,
  input logic       read,
  input logic       write,
  input logic [7:0] writedata,
  input logic [7:0] readdata,
  input logic       waitrequest,
  input logic       phase_late,
  input logic [4:0] pll_ratio_pins,
  input logic [4:0] sys_pll_ratio_r,
  input logic       sys_pll_cfg_valid_r,
  input logic [6:0] delay_line_sel_r,
  input logic       dll_locked_r,
  input logic [7:0] drive_strength_r,
  input logic [1:0] input_timing_sel_r
);
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire rq   = read | write;
  wire done = rq & ~waitrequest;
  wire wr73 = write & (address == 8'h73);
  wire wr77 = write & (address == 8'h77);
  property p_ack; rq && waitrequest |=> !waitrequest; endproperty
  property p_one; !waitrequest |=> waitrequest; endproperty
  property p_cause; $fell(waitrequest) |-> $past(rq); endproperty
  property p_tap_ro;
    done && read && address == 8'he3 |-> readdata[7] == 1'b0;
  endproperty
  property p_unmap;
    done && read && address == 8'h10 |-> readdata == 8'h00;
  endproperty
  // field outputs lag the register, so the cause sits a few edges back
  property p_drv;
    $changed(drive_strength_r) |-> $past(wr73, 2) || $past(wr73, 3);
  endproperty
  property p_tsel;
    $changed(input_timing_sel_r) |-> $past(wr77, 2) || $past(wr77, 3);
  endproperty
  property p_strap;
    $rose(sys_pll_cfg_valid_r) |-> sys_pll_ratio_r == pll_ratio_pins;
  endproperty
  property p_hold;
    sys_pll_cfg_valid_r |=> sys_pll_cfg_valid_r && $stable(sys_pll_ratio_r);
  endproperty
  property p_reinit;
    done && write && address == 8'he0 && writedata[5]
      |-> ##[1:4] !dll_locked_r;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after request");
  a_one: assert property (p_one) else $error("waitrequest low too long");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_tap_ro: assert property (p_tap_ro) else $error("tap bit 7 set");
  a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
  a_drv: assert property (p_drv) else $error("drive changed alone");
  a_tsel: assert property (p_tsel) else $error("timing changed");
  a_strap: assert property (p_strap) else $error("ratio not pins");
  a_hold: assert property (p_hold) else $error("ratio not held");
  a_reinit: assert property (p_reinit) else $error("lock kept");
  c_tap: cover property (done && read && address == 8'he3);
  c_lock: cover property ($rose(dll_locked_r));
  c_wr: cover property ($fell(waitrequest) && write);
endmodule

bind dll_ctrl dll_ctrl_chk #(.TAP_INIT(TAP_INIT), .TAP_OFFSET(TAP_OFFSET),
  .UPDATE_CYC(UPDATE_CYC)) chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .phase_late(phase_late),
  .pll_ratio_pins(pll_ratio_pins), .sys_pll_ratio_r(sys_pll_ratio_r),
  .sys_pll_cfg_valid_r(sys_pll_cfg_valid_r),
  .delay_line_sel_r(delay_line_sel_r), .dll_locked_r(dll_locked_r),
  .drive_strength_r(drive_strength_r),
  .input_timing_sel_r(input_timing_sel_r));

// ### fb_loop_model.sv
/*
  far side model: delay line, feedback trace and phase detector.
  assumes the bench sets the tap at which the loop is aligned.
*/
`timescale 1ns/1ps
module fb_loop_model
#(
  parameter [6:0] FB_OFFSET = 7'h03
)
(
  input  logic       ref_clk,
  input  logic [6:0] delay_line_sel_r,
  input  logic [6:0] target,
  input  logic       slow,
  output logic       phase_late
);
  // ----
  // phase compare
  // ----
  logic [1:0] late_r = 2'b00;
  // internal offset pulls the lock point early: feedback lags the clock
  wire late = delay_line_sel_r > target - FB_OFFSET;
  always @(posedge ref_clk)
    late_r <= {late_r[0], late};
  // slow mode adds detector lag, which makes the loop overshoot
  assign phase_late = slow ? late_r[1] : late;
endmodule

// ### testbench.sv
/*
  self-checking bench for dll_ctrl: register access, lock modes, tap
  reinit and strap capture.
  assumes fb_loop_model on the phase input and a 125 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  localparam [6:0] TOFS = 7'h02;
  localparam [6:0] TINI = 7'h08;
  localparam [6:0] FBO  = 7'h03;
  logic       ref_clk   = 1'b0;
  logic       arst_n    = 1'b0;
  logic [7:0] address   = 8'h00;
  logic       read      = 1'b0;
  logic       write     = 1'b0;
  logic [7:0] writedata = 8'h00;
  logic [4:0] pins      = 5'h15;
  logic [6:0] target    = 7'h1e;
  logic       slow      = 1'b0;
  logic [7:0] readdata, drive, rd, d;
  logic [7:0] best      = 8'hff;
  logic       waitrequest, phase_late, valid, locked;
  logic [4:0] ratio;
  logic [6:0] sel;
  logic [1:0] tsel;
  logic [7:0] regs [0:4] = '{8'h72, 8'h73, 8'h76, 8'h77, 8'he0};
  integer     seed    = 21;
  integer     fails   = 0;
  integer     checked = 0;
  integer     i, m;

  always #4 ref_clk = ~ref_clk;

  dll_ctrl #(.UPDATE_CYC(2)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .phase_late(phase_late),
    .pll_ratio_pins(pins), .sys_pll_ratio_r(ratio),
    .sys_pll_cfg_valid_r(valid), .delay_line_sel_r(sel),
    .dll_locked_r(locked), .drive_strength_r(drive),
    .input_timing_sel_r(tsel));
  fb_loop_model #(.FB_OFFSET(FBO)) far (.ref_clk(ref_clk),
    .delay_line_sel_r(sel), .target(target), .slow(slow),
    .phase_late(phase_late));

  // ----
  // helpers
  // ----
  task test_done;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wait_on(input logic lk, input integer lim);
    integer n;
    begin
      n = 0;
      @(posedge ref_clk);
      while ((lk ? locked : ~waitrequest) !== 1'b1)
      begin
        n = n + 1;
        if (n == lim)
        begin
          chk("wait", 8'h01, 8'h00);
          test_done;
        end
        @(posedge ref_clk);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    begin
      @(posedge ref_clk);
      address <= a;
      writedata <= v;
      write <= 1'b1;
      wait_on(1'b0, 50);
      write <= 1'b0;
    end
  endtask
  task rdr(input logic [7:0] a, output logic [7:0] v);
    begin
      @(posedge ref_clk);
      address <= a;
      read <= 1'b1;
      wait_on(1'b0, 50);
      v = readdata;
      read <= 1'b0;
    end
  endtask
  task do_reset;
    begin
      arst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  // lock dithers around the aligned tap; lag widens the swing
  function automatic logic tap_ok(input logic [7:0] v, input logic [6:0] t);
    logic [7:0] e;
    begin
      e = {1'b0, t - FBO + TOFS};
      tap_ok = (v + 8'h04 >= e) && (v <= e + 8'h04);
    end
  endfunction

  // ----
  // sequence
  // ----
  initial
  begin
    do_reset;
    for (i = 0; i < 5; i = i + 1)
    begin
      rdr(regs[i], rd);
      chk("reset value", 8'h00, rd);
    end
    chk("ratio", {3'h0, pins}, {3'h0, ratio});
    chk("ratio valid", 8'h01, {7'h00, valid});
    for (i = 0; i < 16; i = i + 1)
    begin
      d = $random(seed);
      wr(8'h73, d);
      wr(8'h77, ~d);
      wr(8'h10, d);
      rdr(8'h73, rd);
      chk("drive strength", d, rd);
      chk("drive out", d, drive);
      rdr(8'h77, rd);
      chk("input timing", ~d, rd);
      chk("timing sel", {6'h00, ~d[5:4]}, {6'h00, tsel});
      rdr(8'h10, rd);
      chk("unmapped", 8'h00, rd);
    end
    for (m = 0; m < 4; m = m + 1)
    begin
      do_reset;
      slow <= m[0];
      d = $random(seed);
      target <= (m[1] ? 7'd90 : 7'd30) + {4'h0, d[2:0]};
      wr(8'h72, {m[0], 7'h00});
      wr(8'h76, {5'h00, m[1], 2'h0});
      rdr(8'h76, rd);
      chk("lock mode", {5'h00, m[1], 2'h0}, rd);
      wr(8'he0, 8'h20);
      wr(8'he3, 8'h55);
      rdr(8'he3, rd);
      chk("tap at reinit", {1'b0, TINI}, rd);
      chk("lock at reinit", 8'h00, {7'h00, locked});
      chk("line sel", {1'b0, TINI - TOFS}, {1'b0, sel});
      wr(8'he0, 8'h00);
      wait_on(1'b1, 3000);
      rdr(8'he3, rd);
      chk("locked tap", 8'h01, {7'h00, tap_ok(rd, target)});
      if (rd < best)
        best = rd;
      rdr(8'he4, rd);
      chk("status", {2'h0, pins, 1'b1}, rd);
      wr(8'he0, 8'h20);
      rdr(8'he3, rd);
      chk("tap after reinit", {1'b0, TINI}, rd);
      chk("lock after reinit", 8'h00, {7'h00, locked});
    end
    chk("best tap", 8'h01, {7'h00, best > 8'd12});
    test_done;
  end
endmodule
